// [udmac_regs.svh]
`ifndef UDMAC_REGS_SVH
`define UDMAC_REGS_SVH

// word-aligned byte offsets on the register bus
`define UDMAC_OFF_CTRL      5'h00
`define UDMAC_OFF_EVENTS    5'h04
`define UDMAC_OFF_MASK      5'h08
`define UDMAC_OFF_COUNT     5'h0C
`define UDMAC_OFF_ERROR     5'h10
`define UDMAC_OFF_STATUS    5'h14

// dma_control fields
`define UDMAC_CTL_EN        7
`define UDMAC_CTL_SKIP      6
`define UDMAC_CTL_TGL       5
`define UDMAC_CTL_AUTO      4
`define UDMAC_CTL_MOD       3
`define UDMAC_CTL_SEL_HI    2
`define UDMAC_CTL_SEL_LO    0
`define UDMAC_CTL_RESET     8'h00

// dma_events / dma_event_mask fields
`define UDMAC_EV_HALT       0
`define UDMAC_EV_ERR        1
`define UDMAC_EV_CNT        2
`define UDMAC_EV_SIZ        3
`define UDMAC_EV_NEXT_TOGGLE_STATE       5
`define UDMAC_EV_NUM        4
`define UDMAC_MASK_RESET    4'h0

// dma_error fields
`define UDMAC_ERR_AEH       7
`define UDMAC_ERR_CNT_HI    6

// endpoint select codes at and above this are reserved
`define UDMAC_SEL_LIMIT     3'h6
`define UDMAC_WAIT_RESET    1'b1

`endif

// [udmac_pkg.sv]
`default_nettype none
package udmac_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_SEND  = 5'b00100,
    ST_RECV  = 5'b01000,
    ST_DRAIN = 5'b10000
  } udmac_state_type;

  // status of the selected endpoint FIFO and the serial engine
  typedef struct packed {
    logic tx_complete_flag;
    logic rx_packet_end_flag;
    logic fifo_warning;
    logic fifo_empty;
    logic fifo_full;
    logic packet_done;
    logic packet_toggle;
    logic rx_fault_flag;
    logic handshake_ack_flag;
    logic short_packet;
    logic tx_status_read;
    logic rx_status_read;
    logic tx_final_command;
    logic fw_fifo_access;
    logic fw_ep_reg_access;
  } udmac_ep_in_type;

  // controls returned to the selected endpoint
  typedef struct packed {
    logic [2:0] endpoint_select;
    logic       ep_enable;
    logic       rx_enable;
    logic       tx_enable;
    logic       fifo_flush;
    logic       retry_reschedule;
    logic       toggle_override;
    logic       toggle_value;
  } udmac_ep_out_type;

endpackage : udmac_pkg
`default_nettype wire

// [udmac_evbit.sv]
`timescale 1ns/1ps
`default_nettype none
module udmac_evbit (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_q
);
  // set beats a clear arriving in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end
endmodule : udmac_evbit
`default_nettype wire

// [udmac_top.sv]
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "udmac_regs.svh"
module udmac_top #(
  parameter int CNT_W   = 8,
  parameter int RETRY_W = 7
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic [4:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      host_interface_strap,
  input  wire udmac_pkg::udmac_ep_in_type ep_in,
  output udmac_pkg::udmac_ep_out_type    ep_out,
  output logic                           dma_req,
  output logic                           alternate_event_dma
);
  import udmac_pkg::*;

  logic                      waitrequest_r;
  logic [31:0]               readdata_r;
  logic                      dma_enable_bit_r;
  logic                      skip_rx_toggle_check_r;
  logic                      initial_toggle_value_r;
  logic                      auto_transfer_mode_r;
  logic                      request_timing_select_r;
  logic [2:0]                dma_endpoint_select_r;
  logic [`UDMAC_EV_NUM-1:0]  dma_event_mask_r;
  logic [CNT_W-1:0]          packet_countdown_r;
  logic                      auto_error_recovery_r;
  logic [RETRY_W-1:0]        retry_preset_r;
  logic [RETRY_W-1:0]        retry_budget_counter_r;
  logic                      next_toggle_state_r;
  udmac_state_type           state_r;
  udmac_state_type           state_nxt;
  udmac_ep_out_type          ep_out_r;
  logic                      dma_req_r;
  logic                      alt_dma_r;
  logic [`UDMAC_EV_NUM-1:0]  ev_q;
  logic [`UDMAC_EV_NUM-1:0]  ev_set;
  logic [`UDMAC_EV_NUM-1:0]  ev_clr;

  // engine decision strobes
  logic halt_graceful;
  logic err_set;
  logic cnt_done_ok;
  logic siz_set;
  logic retry_dec;
  logic flush_pulse;
  logic resched_pulse;
  logic start;

  // ---------------- bus slave ----------------
  // every access takes exactly one wait state; keeps read mux off the answer path
  logic req;
  logic wr_acc;
  logic rd_acc;
  assign req    = avs_read | avs_write;
  assign wr_acc = avs_write & ~waitrequest_r;
  assign rd_acc = avs_read & ~waitrequest_r;

  logic wr_ctl;
  logic wr_ev;
  logic wr_mask;
  logic wr_cnt;
  logic wr_err;
  assign wr_ctl  = wr_acc & (avs_address == `UDMAC_OFF_CTRL);
  assign wr_ev   = wr_acc & (avs_address == `UDMAC_OFF_EVENTS);
  assign wr_mask = wr_acc & (avs_address == `UDMAC_OFF_MASK);
  assign wr_cnt  = wr_acc & (avs_address == `UDMAC_OFF_COUNT);
  assign wr_err  = wr_acc & (avs_address == `UDMAC_OFF_ERROR);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_r <= `UDMAC_WAIT_RESET;
    end else begin
      waitrequest_r <= ~(req & waitrequest_r);
    end
  end

  // ---------------- shared terms ----------------
  logic den_eff;
  logic ep_tx;
  logic ep_valid;
  logic run;
  logic ev_any;
  logic abort_now;
  assign den_eff  = dma_enable_bit_r & ~host_interface_strap;
  assign ep_tx    = ~dma_endpoint_select_r[0];
  assign ep_valid = dma_endpoint_select_r < `UDMAC_SEL_LIMIT;
  assign run      = (state_r != ST_IDLE);
  assign ev_any   = |ev_q;
  // enable loss or firmware meddling ends the engine without cleanup
  assign abort_now = run & (~den_eff | ep_in.fw_fifo_access | ep_in.fw_ep_reg_access);
  // start only from idle with every event bit cleared
  assign start = ~run & auto_transfer_mode_r & den_eff & ep_valid & ~ev_any;

  logic pkt_bad;
  logic tgl_mismatch;
  logic pkt_err;
  assign pkt_bad      = ep_tx ? ~ep_in.handshake_ack_flag : ep_in.rx_fault_flag;
  // compared against the toggle before it flips for this packet
  assign tgl_mismatch = (ep_in.packet_toggle != next_toggle_state_r) &
                        (ep_tx | ~skip_rx_toggle_check_r);
  assign pkt_err      = ep_in.packet_done & (pkt_bad | tgl_mismatch);

  // ---------------- control register ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_enable_bit_r        <= 1'b0;
      skip_rx_toggle_check_r  <= 1'b0;
      initial_toggle_value_r  <= 1'b0;
      auto_transfer_mode_r    <= 1'b0;
      request_timing_select_r <= 1'b0;
      dma_endpoint_select_r   <= '0;
    end else if (wr_ctl) begin
      dma_enable_bit_r        <= avs_writedata[`UDMAC_CTL_EN];
      skip_rx_toggle_check_r  <= avs_writedata[`UDMAC_CTL_SKIP];
      initial_toggle_value_r  <= avs_writedata[`UDMAC_CTL_TGL];
      auto_transfer_mode_r    <= avs_writedata[`UDMAC_CTL_AUTO];
      request_timing_select_r <= avs_writedata[`UDMAC_CTL_MOD];
      dma_endpoint_select_r   <= avs_writedata[`UDMAC_CTL_SEL_HI:`UDMAC_CTL_SEL_LO];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_event_mask_r <= `UDMAC_MASK_RESET;
    end else if (wr_mask) begin
      dma_event_mask_r <= avs_writedata[`UDMAC_EV_NUM-1:0];
    end
  end

  // ---------------- next toggle ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_toggle_state_r <= 1'b0;
    end else if (wr_ctl) begin
      next_toggle_state_r <= avs_writedata[`UDMAC_CTL_TGL];
    end else if (ep_valid & ep_in.packet_done & ~pkt_bad) begin
      // a packet with a failed handshake or receive fault keeps its toggle; any other packet on a valid endpoint flips it, even one with a toggle mismatch
      next_toggle_state_r <= ~next_toggle_state_r;
    end
  end

  // ---------------- engine decisions ----------------
  always_comb begin
    state_nxt     = state_r;
    halt_graceful = 1'b0;
    err_set       = 1'b0;
    cnt_done_ok   = 1'b0;
    siz_set       = 1'b0;
    retry_dec     = 1'b0;
    flush_pulse   = 1'b0;
    resched_pulse = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          flush_pulse = 1'b1;
          state_nxt   = ep_tx ? ST_FETCH : ST_RECV;
        end
      end
      ST_FETCH: begin
        if (ep_in.fifo_full) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (pkt_err) begin
          if (auto_error_recovery_r && retry_budget_counter_r != '0) begin
            retry_dec     = 1'b1;
            resched_pulse = 1'b1;
          end else begin
            err_set   = 1'b1;
            state_nxt = ST_IDLE;
          end
        end else if (ep_in.packet_done) begin
          cnt_done_ok = 1'b1;
          if (!auto_transfer_mode_r) begin
            halt_graceful = 1'b1;
            state_nxt     = ST_IDLE;
          end else begin
            state_nxt = ST_FETCH;
          end
        end
      end
      ST_RECV: begin
        if (pkt_err) begin
          if (auto_error_recovery_r && retry_budget_counter_r != '0) begin
            retry_dec   = 1'b1;
            flush_pulse = 1'b1;
          end else begin
            err_set   = 1'b1;
            state_nxt = ST_IDLE;
          end
        end else if (ep_in.packet_done) begin
          siz_set   = ep_in.short_packet;
          state_nxt = ST_DRAIN;
        end else if (!auto_transfer_mode_r) begin
          // nothing in flight, so the halt can complete at once
          halt_graceful = 1'b1;
          state_nxt     = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        if (ep_in.fifo_empty) begin
          cnt_done_ok = 1'b1;
          if (!auto_transfer_mode_r) begin
            halt_graceful = 1'b1;
            state_nxt     = ST_IDLE;
          end else begin
            state_nxt = ST_RECV;
          end
        end
      end
    endcase
    // late events would otherwise stack on a closing engine
    if (abort_now || (run && ev_any)) begin
      state_nxt     = ST_IDLE;
      halt_graceful = 1'b0;
      err_set       = 1'b0;
      cnt_done_ok   = 1'b0;
      siz_set       = 1'b0;
      retry_dec     = 1'b0;
      flush_pulse   = 1'b0;
      resched_pulse = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------- counters ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      packet_countdown_r <= '0;
    end else if (wr_cnt) begin
      packet_countdown_r <= avs_writedata[CNT_W-1:0];
    end else if (cnt_done_ok && packet_countdown_r != '0) begin
      packet_countdown_r <= packet_countdown_r - 1'b1;
    end
  end

  // preset is only writable while the engine is idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_error_recovery_r <= 1'b0;
      retry_preset_r        <= '0;
    end else if (wr_err && !run) begin
      auto_error_recovery_r <= avs_writedata[`UDMAC_ERR_AEH];
      retry_preset_r        <= avs_writedata[RETRY_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_budget_counter_r <= '0;
    end else if (!run || cnt_done_ok || (ep_in.packet_done && !pkt_err)) begin
      retry_budget_counter_r <= retry_preset_r;
    end else if (retry_dec) begin
      retry_budget_counter_r <= retry_budget_counter_r - 1'b1;
    end
  end

  // ---------------- event bits ----------------
  logic fw_fifo_halt;
  logic den_drop;
  assign fw_fifo_halt = ~run & dma_req_r & ep_in.fw_fifo_access;
  assign den_drop     = wr_ctl & dma_enable_bit_r & ~avs_writedata[`UDMAC_CTL_EN];

  always_comb begin
    ev_set                 = '0;
    ev_set[`UDMAC_EV_HALT] = halt_graceful | abort_now | fw_fifo_halt | den_drop;
    ev_set[`UDMAC_EV_ERR]  = err_set;
    ev_set[`UDMAC_EV_CNT]  = cnt_done_ok & (packet_countdown_r == '0) & ~wr_cnt;
    ev_set[`UDMAC_EV_SIZ]  = siz_set & ~ep_tx;
    ev_clr                 = {`UDMAC_EV_NUM{wr_ev}} & avs_writedata[`UDMAC_EV_NUM-1:0];
  end

  generate
    for (genvar i = 0; i < `UDMAC_EV_NUM; i++) begin : g_ev
      udmac_evbit u_evbit (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set_i    (ev_set[i]),
        .clr_i    (ev_clr[i]),
        .flag_q   (ev_q[i])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_dma_r <= 1'b0;
    end else begin
      alt_dma_r <= |(ev_q & dma_event_mask_r);
    end
  end

  // ---------------- DMA request ----------------
  logic req_norm;
  logic req_auto;
  always_comb begin
    if (request_timing_select_r) begin
      req_norm = ep_tx ? (ep_in.fifo_warning & ~ep_in.tx_complete_flag)
                       : (ep_in.fifo_warning & ~ep_in.fifo_empty);
    end else begin
      req_norm = ep_tx ? (ep_in.tx_complete_flag & ~ep_in.tx_status_read & ~ep_in.tx_final_command)
                       : (ep_in.rx_packet_end_flag & ~ep_in.rx_status_read & ~ep_in.fifo_empty);
    end
    // auto mode ignores the timing select, asking only around packets
    req_auto = ((state_nxt == ST_FETCH) & ~ep_in.fifo_full) |
               ((state_nxt == ST_DRAIN) & ~ep_in.fifo_empty);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_req_r <= 1'b0;
    end else begin
      dma_req_r <= den_eff & ep_valid & ~abort_now & ~fw_fifo_halt & ~den_drop &
                   (run | auto_transfer_mode_r ? req_auto : req_norm);
    end
  end

  // ---------------- endpoint controls ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ep_out_r <= '0;
    end else begin
      ep_out_r.endpoint_select  <= dma_endpoint_select_r;
      ep_out_r.ep_enable        <= ep_out_r.ep_enable | start;
      ep_out_r.rx_enable        <= (state_nxt == ST_RECV);
      ep_out_r.tx_enable        <= (state_nxt == ST_SEND);
      ep_out_r.fifo_flush       <= flush_pulse;
      ep_out_r.retry_reschedule <= resched_pulse;
      ep_out_r.toggle_override  <= (state_nxt != ST_IDLE) & ep_tx;
      ep_out_r.toggle_value     <= next_toggle_state_r;
    end
  end

  // ---------------- read mux ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_r <= '0;
    end else if (avs_read && waitrequest_r) begin
      readdata_r <= '0;
      unique case (avs_address)
        `UDMAC_OFF_CTRL: begin
          readdata_r[`UDMAC_CTL_EN]   <= dma_enable_bit_r;
          readdata_r[`UDMAC_CTL_SKIP] <= skip_rx_toggle_check_r;
          readdata_r[`UDMAC_CTL_TGL]  <= initial_toggle_value_r;
          readdata_r[`UDMAC_CTL_AUTO] <= auto_transfer_mode_r;
          readdata_r[`UDMAC_CTL_MOD]  <= request_timing_select_r;
          readdata_r[`UDMAC_CTL_SEL_HI:`UDMAC_CTL_SEL_LO] <= dma_endpoint_select_r;
        end
        `UDMAC_OFF_EVENTS: begin
          readdata_r[`UDMAC_EV_NUM-1:0] <= ev_q;
          readdata_r[`UDMAC_EV_NEXT_TOGGLE_STATE]    <= next_toggle_state_r;
        end
        `UDMAC_OFF_MASK: begin
          readdata_r[`UDMAC_EV_NUM-1:0] <= dma_event_mask_r;
        end
        `UDMAC_OFF_COUNT: begin
          readdata_r[CNT_W-1:0] <= packet_countdown_r;
        end
        `UDMAC_OFF_ERROR: begin
          readdata_r[`UDMAC_ERR_AEH] <= auto_error_recovery_r;
          readdata_r[RETRY_W-1:0]    <= run ? retry_budget_counter_r : retry_preset_r;
        end
        `UDMAC_OFF_STATUS: begin
          readdata_r[4:0] <= state_r;
          readdata_r[8]   <= dma_req_r;
        end
        default: begin
          readdata_r <= '0;
        end
      endcase
    end
  end

  assign avs_readdata        = readdata_r;
  assign avs_waitrequest     = waitrequest_r;
  assign ep_out              = ep_out_r;
  assign dma_req             = dma_req_r;
  assign alternate_event_dma = alt_dma_r;
endmodule : udmac_top
`default_nettype wire

// [udmac_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module udmac_top_properties #(
  parameter int CNT_W   = 8,
  parameter int RETRY_W = 7
) (
  input wire logic                        core_clk,
  input wire logic                        rst_n,
  input wire logic [4:0]                  avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_writedata,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        host_interface_strap,
  input wire udmac_pkg::udmac_ep_in_type  ep_in,
  input wire udmac_pkg::udmac_ep_out_type ep_out,
  input wire logic                        dma_req,
  input wire logic                        alternate_event_dma
);
  import udmac_pkg::*;
  logic [7:0] ctrl_r;
  logic [3:0] mask_r;
  logic       tgl_r;
  wire        ctl_wr = avs_write && !avs_waitrequest && avs_address == 5'h00;
  wire        ena    = ctrl_r[7] && !ctrl_r[4] && !host_interface_strap;
  // shadow of what firmware wrote, so request rules can name their cause
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 8'h00;
      mask_r <= 4'h0;
      tgl_r  <= 1'b0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 5'h00) ctrl_r <= avs_writedata[7:0];
      if (avs_address == 5'h00) tgl_r <= avs_writedata[5];
      if (avs_address == 5'h08) mask_r <= avs_writedata[3:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  sel_reserved_a: assert property (ctrl_r[2:1] == 2'b11 |=> !dma_req) else $error("reserved select served");
  strap_off_a: assert property (host_interface_strap |=> !dma_req) else $error("request under strap");
  tx_hold_a: assert property (ena && !ctrl_r[3] && !ctrl_r[0] && !ep_in.tx_complete_flag |=> !dma_req)
    else $error("tx request without completion");
  warn_req_a: assert property (ena && ctrl_r[3] && ctrl_r[0] && ctrl_r[2:1] != 2'b11 && ep_in.fifo_warning
    && !ep_in.fifo_empty && !ctl_wr |=> dma_req) else $error("warning request missing");
  rx_empty_a: assert property (ctrl_r[0] && ep_in.fifo_empty |=> !dma_req) else $error("request on empty rx");
  halt_event_a: assert property (ctl_wr && ctrl_r[7] && !avs_writedata[7] && mask_r[0]
    |-> ##[1:3] alternate_event_dma) else $error("halt event not flagged");
  toggle_load_a: assert property (ctl_wr |=> ##[0:1] ep_out.toggle_value == tgl_r) else $error("toggle not loaded");
  auto_flush_a: assert property ($rose(ep_out.ep_enable) |-> ep_out.fifo_flush || $past(ep_out.fifo_flush))
    else $error("enable without flush");
  tx_override_a: assert property (ctrl_r[4] && ep_out.tx_enable |-> ep_out.toggle_override)
    else $error("auto tx toggle not overridden");
endmodule : udmac_top_properties
bind udmac_top udmac_top_properties #(.CNT_W(CNT_W), .RETRY_W(RETRY_W)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .host_interface_strap(host_interface_strap), .ep_in(ep_in),
  .ep_out(ep_out), .dma_req(dma_req), .alternate_event_dma(alternate_event_dma));
`default_nettype wire

// [udmac_dma_model.sv]
`timescale 1ns/1ps
`default_nettype none
module udmac_dma_model #(
  parameter int DEPTH = 8
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       dma_req,
  input wire logic       fill,
  input wire logic       slow,
  input wire logic       flush,
  input wire logic       load,
  input wire logic [3:0] load_lvl,
  output logic           full,
  output logic           empty
);
  logic [3:0] lvl_r;
  logic       tick_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r  <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= ~tick_r;
      if (load) lvl_r <= load_lvl;
      else if (flush) lvl_r <= 4'h0;
      else if (dma_req && (!slow || tick_r)) begin
        // slow mode moves a byte every other cycle to stretch the request
        if (fill && lvl_r < 4'(DEPTH)) lvl_r <= lvl_r + 4'h1;
        else if (!fill && lvl_r != 4'h0) lvl_r <= lvl_r - 4'h1;
      end
    end
  end
  assign full  = lvl_r == 4'(DEPTH);
  assign empty = lvl_r == 4'h0;
endmodule : udmac_dma_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import udmac_pkg::*;
  typedef struct {logic [4:0] a; logic [7:0] d; logic [31:0] e;} udmac_row_type;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [4:0]       avs_address = 5'h00;
  logic             avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0, avs_readdata, q;
  logic             avs_waitrequest, strap = 1'b0, dma_req, alt_ev, full, empty, slow = 1'b0, load = 1'b0;
  logic [3:0]       load_lvl = 4'h0;
  udmac_ep_in_type  ep_tb = '0, ep_in;
  udmac_ep_out_type ep_out;
  int               n_fail = 0, num_checks = 0, cycles = 0;
  udmac_row_type    rows [8] = '{'{5'h00, 8'h0B, 32'h0B}, '{5'h08, 8'hFF, 32'h0F}, '{5'h0C, 8'hA5, 32'hA5},
    '{5'h10, 8'h05, 32'h05}, '{5'h18, 8'hFF, 32'h00}, '{5'h04, 8'h0F, 32'h00},
    '{5'h14, 8'hFF, 32'h01}, '{5'h00, 8'h00, 32'h00}};
  always #12.5 core_clk = ~core_clk;
  always_comb begin
    ep_in = ep_tb;
    ep_in.fifo_full = full;
    ep_in.fifo_empty = empty;
  end
  udmac_top #(.CNT_W(8), .RETRY_W(7)) dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_interface_strap(strap), .ep_in(ep_in), .ep_out(ep_out),
    .dma_req(dma_req), .alternate_event_dma(alt_ev));
  udmac_dma_model #(.DEPTH(8)) u_dma (.core_clk(core_clk), .rst_n(rst_n), .dma_req(dma_req),
    .fill(!ep_out.endpoint_select[0]), .slow(slow), .flush(ep_out.fifo_flush), .load(load),
    .load_lvl(load_lvl), .full(full), .empty(empty));
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s", $time, m);
      n_fail++;
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    // no local limit: a slave that never answers is caught by the cycle ceiling
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 8'h00);
    chk(q, e, m);
  endtask : rd_chk
  task automatic wait_req(input logic v, input string m);
    int t = 0;
    while (dma_req !== v && t < 60) begin
      @(posedge core_clk);
      t++;
    end
    chk(dma_req, v, m);
  endtask : wait_req
  task automatic preload(input logic [3:0] lvl);
    load_lvl <= lvl;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
  endtask : preload
  task automatic no_req();
    repeat (5) begin
      @(posedge core_clk);
      chk(dma_req, 1'b0, "refused request raised");
    end
  endtask : no_req
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(5'h00, 32'h00, "control reset");
    rd_chk(5'h04, 32'h00, "events reset");
    rd_chk(5'h08, 32'h00, "mask reset");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e, "register row");
    end
    bus(1'b1, 5'h00, 8'h80);
    ep_tb.tx_complete_flag <= 1'b1;
    wait_req(1'b1, "tx completion request");
    ep_tb.tx_status_read <= 1'b1;
    ep_tb.tx_complete_flag <= 1'b0;
    @(posedge core_clk);
    ep_tb.tx_status_read <= 1'b0;
    wait_req(1'b0, "tx request kept");
    preload(4'h5);
    slow <= 1'b1;
    ep_tb.fifo_warning <= 1'b1;
    bus(1'b1, 5'h00, 8'h89);
    wait_req(1'b1, "warning request");
    wait_req(1'b0, "rx request past empty");
    chk(empty, 1'b1, "rx not drained");
    for (int i = 0; i < 3; i++) begin
      strap <= (i == 2);
      bus(1'b1, 5'h00, (i == 2) ? 8'h89 : 8'h8E + 8'(i));
      preload(4'h5);
      no_req();
    end
    strap <= 1'b0;
    wait_req(1'b1, "request after strap");
    bus(1'b1, 5'h00, 8'h09);
    rd_chk(5'h04, 32'h01, "soft halt");
    chk(alt_ev, 1'b1, "masked halt event");
    chk(dma_req, 1'b0, "request after disable");
    bus(1'b1, 5'h04, 8'h0F);
    rd_chk(5'h04, 32'h00, "events not cleared");
    bus(1'b1, 5'h00, 8'h20);
    rd_chk(5'h04, 32'h20, "toggle load");
    chk(ep_out.toggle_value, 1'b1, "toggle output");
    ep_tb.fifo_warning <= 1'b0;
    slow <= 1'b0;
    // pass 0 loses the handshake, pass 1 completes the last counted packet, pass 2 retries
    for (int i = 0; i < 3; i++) begin
      if (i == 2) bus(1'b1, 5'h10, 8'h81);
      bus(1'b1, 5'h0C, 8'h00);
      bus(1'b1, 5'h00, 8'h10);
      bus(1'b1, 5'h00, 8'h90);
      wait_req(1'b1, "fetch request");
      chk(ep_out.ep_enable, 1'b1, "endpoint enable");
      wait_req(1'b0, "fetch past full");
      for (int t = 0; t < 20 && ep_out.tx_enable !== 1'b1; t++) @(posedge core_clk);
      chk(ep_out.tx_enable, 1'b1, "transmit enable");
      chk(ep_out.toggle_override, 1'b1, "toggle override");
      ep_tb.packet_done <= 1'b1;
      ep_tb.handshake_ack_flag <= (i == 1);
      ep_tb.packet_toggle <= 1'b0;
      @(posedge core_clk);
      ep_tb.packet_done <= 1'b0;
      preload(4'h0);
      chk(ep_out.retry_reschedule, (i == 2), "retry reschedule");
      no_req();
      rd_chk(5'h04, (i == 1) ? 32'h24 : (i == 0) ? 32'h02 : 32'h00, "auto stop event");
      chk(ep_out.toggle_value, (i == 1), "next toggle");
      bus(1'b1, 5'h00, 8'h00);
      bus(1'b1, 5'h04, 8'h0F);
    end
    // auto receive: one good packet lands, is drained, and the zero count stops the engine
    bus(1'b1, 5'h00, 8'h11);
    bus(1'b1, 5'h00, 8'h91);
    for (int t = 0; t < 20 && ep_out.rx_enable !== 1'b1; t++) @(posedge core_clk);
    chk(ep_out.rx_enable, 1'b1, "receive enable");
    ep_tb.packet_done <= 1'b1;
    preload(4'h3);
    ep_tb.packet_done <= 1'b0;
    wait_req(1'b1, "drain request");
    wait_req(1'b0, "drain past empty");
    chk(empty, 1'b1, "rx packet not drained");
    rd_chk(5'h04, 32'h24, "auto rx stop event");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
